// ===== core/sarc_ctrl.sv
// Control, sequencing and output-enable logic of the successive-approximation converter.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - The start transition captures byte_select, low giving a 12-bit and high an 8-bit conversion.
// - After an 8-bit conversion a full read shows the three lowest bits zero and data_bit_three one.
// - Only byte_select is latched at start; all other controls act live.
// - A conversion starts when enable is high, select low and read/convert low, set by the last to arrive.
// - conversion_busy is high only while a conversion runs.
// - While busy the data outputs stay disabled whatever the controls do.
// - A start request while busy is ignored and neither resets nor restarts the conversion.
// - Data outputs enable only with read/convert high, busy low, enable high and select low together.
// - With width_select high a read enables all 12 outputs and ignores byte_select.
// - With width_select low and byte_select low a read enables only the 8 top result bits.
// - With width_select low and byte_select high the top four are off, bits 4 to 7 low, 4 low bits shown.
// - When switching bytes, the old byte drivers turn off before the new ones turn on.
module sarc_ctrl
  import sarc_pkg::*;
#(
  parameter int FULL_BITS = SARC_FULL_BITS,
  parameter int SHORT_BITS = SARC_SHORT_BITS,
  parameter int CYCLES_PER_BIT = SARC_CYCLES_PER_BIT
)
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic chip_enable_i,
  input wire logic chip_select_n_i,
  input wire logic read_convert_i,
  input wire logic width_select_i,
  input wire logic byte_select_i,
  input wire logic comparator_i,
  output logic conversion_busy_o,
  output logic [11:0] dac_code_o,
  output logic [11:0] data_o,
  output logic [11:0] data_oe_o
);
  sarc_ctrl_t ctl;
  logic start_cond;
  logic start_cond_q;
  sarc_state_t state_q;
  logic short_q;
  logic [3:0] bit_idx_q;
  logic [7:0] cyc_q;
  logic [11:0] trial_q;
  logic [11:0] result_q;
  logic busy_q;
  logic [11:0] oe_q;
  logic [11:0] data_q;
  logic [11:0] oe_target;
  logic [11:0] data_view;
  logic [3:0] last_idx;

  // Every control pin is asynchronous to sys_clk_i, so each one passes its own synchroniser.
  // All five have the same latency, so pins that move together also move together here, and a
  // start can never be built from a half-updated set of controls.
  sarc_sync #(.RESET_VAL(1'b0)) u_sync_ce (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(chip_enable_i), .sync_o(ctl.chip_enable));
  sarc_sync #(.RESET_VAL(1'b1)) u_sync_cs (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(chip_select_n_i), .sync_o(ctl.chip_select_n));
  sarc_sync #(.RESET_VAL(1'b1)) u_sync_rc (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(read_convert_i), .sync_o(ctl.read_convert));
  sarc_sync #(.RESET_VAL(1'b1)) u_sync_ws (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(width_select_i), .sync_o(ctl.width_select));
  sarc_sync #(.RESET_VAL(1'b0)) u_sync_bs (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(byte_select_i), .sync_o(ctl.byte_select));

  // Whichever qualifier arrives last makes this rise.
  assign start_cond = ctl.chip_enable && !ctl.chip_select_n && !ctl.read_convert;
  assign last_idx = short_q ? 4'(FULL_BITS - SHORT_BITS) : 4'h0;

  // Edge detector for the start condition. Its reset value matches the idle level of the
  // synchronised controls, so releasing reset cannot fake a start.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      start_cond_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      start_cond_q <= start_cond;
    end
  end

  // Sequencer: one bit decision every CYCLES_PER_BIT clocks, MSB first.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= SARC_IDLE;
      short_q <= 1'b0;
      bit_idx_q <= 4'h0;
      cyc_q <= 8'h00;
      trial_q <= SARC_RESULT_RESET;
      result_q <= SARC_RESULT_RESET;
      busy_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      case (state_q)
        SARC_IDLE:
        begin
          // Starts seen while converting never reach here, so they are dropped.
          if (start_cond && !start_cond_q)
          begin
            short_q <= ctl.byte_select;
            bit_idx_q <= 4'(FULL_BITS - 1);
            cyc_q <= 8'h00;
            trial_q <= 12'h800;
            busy_q <= 1'b1;
            state_q <= SARC_CONVERT;
          end
        end
        SARC_CONVERT:
        begin
          if (cyc_q == 8'(CYCLES_PER_BIT - 1))
          begin
            cyc_q <= 8'h00;
            if (!comparator_i)
            begin
              trial_q[bit_idx_q] <= 1'b0;
            end
            if (bit_idx_q == last_idx)
            begin
              // Short result: low three bits zero, data_bit_three forced high.
              if (short_q)
              begin
                // The last decision comes straight from comparator_i, since its trial bit is
                // still being written in this same cycle.
                result_q <= {trial_q[11:5], comparator_i, 4'h0} | (12'h001 << SARC_DATA_BIT_THREE);
              end
              else
              begin
                result_q <= {trial_q[11:1], comparator_i};
              end
              busy_q <= 1'b0;
              state_q <= SARC_IDLE;
            end
            else
            begin
              trial_q[bit_idx_q - 4'h1] <= 1'b1;
              bit_idx_q <= bit_idx_q - 4'h1;
            end
          end
          else
          begin
            cyc_q <= cyc_q + 8'h01;
          end
        end
        default:
        begin
          // An illegal state code falls back to idle and clears busy.
          state_q <= SARC_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Output enable decode. Nothing but byte_select is ever stored, so all other controls act
  // live here; byte_select only reaches the sequencer at the moment of a start.
  always_comb
  begin
    oe_target = SARC_OE_NONE;
    data_view = result_q;
    if (ctl.read_convert && !busy_q && ctl.chip_enable && !ctl.chip_select_n)
    begin
      if (ctl.width_select)
      begin
        oe_target = SARC_OE_ALL;
      end
      else if (!ctl.byte_select)
      begin
        oe_target = SARC_OE_HIGH_BYTE;
        data_view = {result_q[11:4], 4'h0};
      end
      else
      begin
        // Top four lines quiet, lines 7 to 4 driven low, result low nibble on lines 3 to 0, so the
        // second byte reads left justified when the low lines are strapped to the upper ones.
        oe_target = SARC_OE_LOW_BYTE;
        data_view = {8'h00, result_q[3:0]};
      end
    end
  end

  // Byte changeover goes through an all-off cycle first.
  // The price is one extra idle bus cycle, which a host reading both bytes back to back must allow.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      oe_q <= SARC_OE_NONE;
      data_q <= SARC_RESULT_RESET;
    end
    else if (clk_en_i)
    begin
      data_q <= data_view;
      if ((oe_q != SARC_OE_NONE) && (oe_target != oe_q) && (oe_target != SARC_OE_NONE))
      begin
        oe_q <= SARC_OE_NONE;
      end
      else
      begin
        oe_q <= oe_target;
      end
    end
  end

  assign conversion_busy_o = busy_q;
  assign dac_code_o = trial_q;
  assign data_o = data_q;
  assign data_oe_o = oe_q;
endmodule // sarc_ctrl
`default_nettype wire

// ===== core/sarc_pkg.sv
// Package with shared constants and types for the converter control block.
package sarc_pkg;
  localparam int SARC_FULL_BITS = 12;
  localparam int SARC_SHORT_BITS = 8;
  // Clock cycles spent on each bit decision.
  localparam int SARC_CYCLES_PER_BIT = 4;
  // Cycles for break-before-make gap between byte drivers.
  localparam int SARC_BBM_CYCLES = 1;
  localparam logic [11:0] SARC_RESULT_RESET = 12'h000;
  localparam logic [11:0] SARC_OE_NONE = 12'h000;
  localparam logic [11:0] SARC_OE_ALL = 12'hfff;
  localparam logic [11:0] SARC_OE_HIGH_BYTE = 12'hff0;
  localparam logic [11:0] SARC_OE_LOW_BYTE = 12'h0ff;
  localparam int SARC_DATA_BIT_THREE = 3;

  typedef enum logic [1:0] {
    SARC_IDLE = 2'b00,
    SARC_CONVERT = 2'b01
  } sarc_state_t;

  // Live control inputs after synchronisation.
  typedef struct packed {
    logic chip_enable;
    logic chip_select_n;
    logic read_convert;
    logic width_select;
    logic byte_select;
  } sarc_ctrl_t;
endpackage : sarc_pkg

// ===== core/sarc_sync.sv
// Three-stage input synchroniser with agreement-based change detection.
`timescale 1ns/1ps
`default_nettype none
module sarc_sync
  import sarc_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      out_q <= RESET_VAL;
    end
    else if (clk_en_i)
    begin
      meta_q <= async_i;
      s2_q <= meta_q;
      s3_q <= s2_q;
      // A change counts only once the last two stages agree.
      if (s2_q == s3_q)
      begin
        out_q <= s3_q;
      end
    end
  end

  assign sync_o = out_q;
endmodule // sarc_sync
`default_nettype wire

// ===== dv/sarc_comp_model.sv
// Behavioural comparator on the analog side of the converter.
`timescale 1ns/1ps
`default_nettype none
module sarc_comp_model (
  input wire logic [11:0] dac_code_i,
  input wire logic [11:0] target_i,
  output logic keep_o
);
  // The trial bit stays while the trial code does not exceed the held input.
  assign keep_o = dac_code_i <= target_i;
endmodule // sarc_comp_model
`default_nettype wire

// ===== dv/sarc_ctrl_assertions.sv
// Port-level checks for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module sarc_ctrl_assertions
  import sarc_pkg::*;
#(parameter int FULL_BITS = SARC_FULL_BITS, parameter int SHORT_BITS = SARC_SHORT_BITS,
  parameter int CYCLES_PER_BIT = SARC_CYCLES_PER_BIT)
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic chip_enable_i,
  input wire logic chip_select_n_i,
  input wire logic read_convert_i,
  input wire logic width_select_i,
  input wire logic conversion_busy_o,
  input wire logic [11:0] data_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  int cnt_q;
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
    if (!reset_n_i) cnt_q <= 0;
    else if (clk_en_i) cnt_q <= conversion_busy_o ? cnt_q + 1 : 0;
  chk_busy_no_oe: assert property (conversion_busy_o |-> data_oe_o == 12'h000)
    else $error("enabled while busy");
  chk_oe_codes: assert property (data_oe_o inside {12'h000, 12'hfff, 12'hff0, 12'h0ff})
    else $error("bad enable pattern");
  chk_bbm_hi_lo: assert property (data_oe_o == 12'hff0 |=> data_oe_o != 12'h0ff)
    else $error("no byte gap");
  chk_bbm_lo_hi: assert property (data_oe_o == 12'h0ff |=> data_oe_o != 12'hff0)
    else $error("no byte gap");
  chk_busy_len: assert property ($fell(conversion_busy_o) |->
    cnt_q == FULL_BITS * CYCLES_PER_BIT || cnt_q == SHORT_BITS * CYCLES_PER_BIT)
    else $error("bad busy length");
  chk_start_cond: assert property ($rose(conversion_busy_o) |->
    $past(chip_enable_i, 2) && !$past(chip_select_n_i, 2) && !$past(read_convert_i, 2))
    else $error("busy without start");
  chk_read_cond: assert property (data_oe_o != 12'h000 && $past(data_oe_o) == 12'h000 |->
    $past(read_convert_i, 2) && $past(chip_enable_i, 2) && !$past(chip_select_n_i, 2))
    else $error("enabled without read");
  chk_full_width: assert property (data_oe_o == 12'hfff && $past(data_oe_o) != 12'hfff |->
    $past(width_select_i, 2))
    else $error("full width without select");
endmodule // sarc_ctrl_assertions
bind sarc_ctrl sarc_ctrl_assertions #(.FULL_BITS(FULL_BITS), .SHORT_BITS(SHORT_BITS),
  .CYCLES_PER_BIT(CYCLES_PER_BIT)) u_chk (.*);
`default_nettype wire

// ===== dv/tb.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb
  import sarc_pkg::*;
();
  // Mode bits are {short conversion, width select, byte select at read}.
  typedef struct packed {logic [2:0] m; logic [11:0] tg; logic [11:0] oe; logic [11:0] dt;} sarc_row_t;
  sarc_row_t rows [4] = '{'{3'h2, 12'ha5c, 12'hfff, 12'ha5c}, '{3'h0, 12'ha5c, 12'hff0, 12'ha50},
    '{3'h1, 12'ha5c, 12'h0ff, 12'h00c}, '{3'h7, 12'h3e7, 12'hfff, 12'h3e8}};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic en = 1'h1;
  logic gap = 1'h0;
  sarc_ctrl_t c = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
  logic [11:0] tg = 12'h000;
  logic [11:0] dac, dat, oe;
  logic busy, keep;
  int bad_count = 0;
  int check_count = 0;
  int n;
  realtime t0;
  initial forever #12.5 clk = ~clk;
  sarc_ctrl DUT (.sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(en), .chip_enable_i(c.chip_enable),
    .chip_select_n_i(c.chip_select_n), .read_convert_i(c.read_convert), .width_select_i(c.width_select),
    .byte_select_i(c.byte_select), .comparator_i(keep), .conversion_busy_o(busy), .dac_code_o(dac),
    .data_o(dat), .data_oe_o(oe));
  sarc_comp_model u_cmp (.dac_code_i(dac), .target_i(tg), .keep_o(keep));
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (!ok)
    begin
      $display("ERROR %0t %s", $time, m);
      bad_count++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic drv(input sarc_ctrl_t v, input int k);
    @(posedge clk);
    c <= v;
    repeat (k) @(posedge clk);
  endtask
  task automatic wbusy(input logic v);
    for (n = 0; busy !== v && n < 300; n++)
      @(negedge clk);
    if (n >= 300)
    begin
      chk(1'h0, "timeout");
      results();
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    chk(busy === 1'h0 && oe === 12'h000, "reset");
    rst_n <= 1'h1;
    $display("reset done");
    foreach (rows[i])
    begin
      tg <= rows[i].tg;
      drv('{1'h1, 1'h0, 1'h1, 1'h1, rows[i].m[2]}, 4);
      drv('{1'h1, 1'h0, 1'h0, 1'h1, rows[i].m[2]}, 0);
      wbusy(1'h1);
      t0 = $realtime;
      // A read attempt and a second start while busy, with byte select driven low, off its latched value only in the short-conversion row.
      drv('{1'h1, 1'h0, 1'h1, 1'h1, 1'h0}, 3);
      drv('{1'h1, 1'h0, 1'h0, 1'h1, 1'h0}, 0);
      wbusy(1'h0);
      chk($realtime - t0 == 25.0 * SARC_CYCLES_PER_BIT * (rows[i].m[2] ? SARC_SHORT_BITS : SARC_FULL_BITS),
        "length");
      drv('{1'h1, 1'h0, 1'h1, rows[i].m[1], rows[i].m[0]}, 0);
      for (n = 0; oe !== rows[i].oe && n < 12; n++)
        @(negedge clk);
      chk(oe === rows[i].oe && dat === rows[i].dt, "read");
      $display("row %0d done", i);
    end
    // Freezing the enable for 20 cycles mid-conversion must stretch the run by exactly that much.
    tg <= 12'h123;
    drv('{1'h1, 1'h0, 1'h1, 1'h1, 1'h0}, 4);
    drv('{1'h1, 1'h0, 1'h0, 1'h1, 1'h0}, 0);
    wbusy(1'h1);
    t0 = $realtime;
    @(posedge clk);
    en <= 1'h0;
    repeat (20) @(posedge clk);
    en <= 1'h1;
    wbusy(1'h0);
    chk($realtime - t0 == 25.0 * (SARC_CYCLES_PER_BIT * SARC_FULL_BITS + 20), "freeze length");
    $display("freeze done");
    // A byte switch in mid-read must pass through an all-off cycle.
    drv('{1'h1, 1'h0, 1'h1, 1'h0, 1'h0}, 0);
    for (n = 0; oe !== 12'hff0 && n < 12; n++)
      @(negedge clk);
    chk(oe === 12'hff0 && dat === 12'h120, "high byte");
    drv('{1'h1, 1'h0, 1'h1, 1'h0, 1'h1}, 0);
    for (n = 0; oe !== 12'h0ff && n < 12; n++)
    begin
      @(negedge clk);
      gap = gap | (oe === 12'h000);
    end
    chk(gap && oe === 12'h0ff && dat === 12'h003, "byte switch");
    $display("byte switch done");
    // Reset in mid-conversion aborts it, and release with the read state held starts nothing.
    drv('{1'h1, 1'h0, 1'h0, 1'h1, 1'h0}, 0);
    wbusy(1'h1);
    @(posedge clk);
    rst_n <= 1'h0;
    drv('{1'h1, 1'h0, 1'h1, 1'h1, 1'h0}, 2);
    chk(busy === 1'h0 && oe === 12'h000 && dat === 12'h000, "reset mid-run");
    rst_n <= 1'h1;
    for (n = 0; oe !== 12'hfff && n < 12; n++)
      @(negedge clk);
    chk(busy === 1'h0 && oe === 12'hfff && dat === 12'h000, "after reset");
    $display("mid-run reset done");
    for (int i = 0; i < 2; i++)
    begin
      drv('{i[0], i[0], 1'h0, 1'h1, 1'h0}, 10);
      chk(busy === 1'h0, "start");
      drv('{i[0], i[0], 1'h1, 1'h1, 1'h0}, 10);
      chk(oe === 12'h000, "read");
    end
    $display("idle done");
    results();
  end
endmodule // tb
`default_nettype wire
